/* src/audio_serial_port.sv */
/*
 Multichannel TDM audio serial port: bit clock and frame clock master or slave, four
 framing formats, eight TX and eight RX channels placed in time slots.
 Assumes config is held steady while channels run; TX samples come in per channel with
 valid/ready, RX samples leave through a two-entry buffer.
*/
// Functional notes
// - Eight TX and eight RX channels, TX and RX configured separately; instantiate twice.
//   Here TX and RX share format, lengths and clocks; only enables and slots are separate.
// - Pins: serial data out, serial data in, bit clock, frame clock.
// - Master drives both clocks; slave takes them from the partner.
// - Formats DSP A, DSP B, I2S, left-justified.
// - Left-justified and DSP B only allowed when master of both clocks.
// - Words shifted MSB first on transmit and receive.
// - Samples are signed two's complement, passed through unchanged.
// - DSP: MSB on first (B) or second (A) bit clock rise after frame rise.
// - DSP: right slot follows left LSB directly; trailing clocks unused.
// - Mono PCM uses the left (slot zero) position both ways.
// - I2S: MSB on second rise after each frame clock edge.
// - Left-justified: MSB on first rise after each frame clock edge.
// - Bit clock and frame clock polarities can be inverted.
// - Single stereo pair sits in slot zero.
// - All channels of a port share one frame rate.
// - Each channel enabled separately, one assigned slot each.
// - DSP slots consecutive; I2S/LJ even slots first half, odd second.
// - Slot length, word length and frame length are configurable.
// - Data output may tristate outside own slots, selectable behaviour.
// - Master clocks run only while a channel is enabled, unless forced.
// - Frame clock is derived from the bit clock.
`timescale 1ns/1ps
module audio_serial_port #(
	parameter int CHANNELS = audio_serial_port_pkg::CHANNELS,
	parameter int WORD_MAX = audio_serial_port_pkg::WORD_MAX
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire audio_serial_port_pkg::port_cfg_s cfg,
	input wire logic [CHANNELS*WORD_MAX-1:0] tx_sample,
	input wire logic [CHANNELS-1:0] tx_valid,
	output logic [CHANNELS-1:0] tx_ready,
	output audio_serial_port_pkg::sample_s rx_sample,
	output logic rx_valid,
	input wire logic rx_ready,
	output logic rx_overrun,
	output logic cfg_error,
	output logic serial_data_out,
	output logic serial_data_out_oe,
	input wire logic serial_data_in,
	input wire logic bclk_in,
	output logic bclk_out,
	output logic bclk_oe,
	input wire logic lrclk_in,
	output logic lrclk_out,
	output logic lrclk_oe
);
	localparam int LW = audio_serial_port_pkg::LEN_W;
	localparam int FW = audio_serial_port_pkg::FRAME_W;
	localparam int CW = audio_serial_port_pkg::CH_W;

	function automatic logic [CW-1:0] slot_of(input logic [CHANNELS*CW-1:0] map, input int ch);
		slot_of = map[ch*CW +: CW];
	endfunction

	// Word-bit flag, slot and bit in slot for a bit count; slots past the last are dropped
	function automatic logic [CW+LW:0] slot_decode(input audio_serial_port_pkg::port_cfg_s c,
		input logic [FW-1:0] cnt);
		logic dsp;
		logic upper;
		logic [FW-1:0] half;
		logic [FW-1:0] ld;
		logic [FW-1:0] hp;
		logic [FW-1:0] p;
		logic [FW-1:0] idx;
		logic [CW-1:0] sl;
		logic [LW-1:0] b;
		logic ok;
		dsp = (c.format == audio_serial_port_pkg::fmt_dsp_a)
			|| (c.format == audio_serial_port_pkg::fmt_dsp_b);
		half = {1'b0, c.frame_len[FW-1:1]};
		ld = '0;
		if (c.format == audio_serial_port_pkg::fmt_dsp_a
			|| c.format == audio_serial_port_pkg::fmt_i2s) begin
			ld = FW'(1);
		end
		upper = !dsp && (cnt >= half);
		hp = upper ? cnt - half : cnt;
		p = hp - ld;
		idx = '0;
		b = '0;
		if (c.slot_len != '0) begin
			idx = p / c.slot_len;
			b = LW'(p % c.slot_len);
		end
		if (dsp) begin
			sl = CW'(idx);
		end else begin
			sl = CW'({idx, upper});
		end
		ok = (hp >= ld) && (c.slot_len != '0) && (b < c.word_len)
			&& (idx < (dsp ? FW'(CHANNELS) : FW'(CHANNELS / 2)));
		slot_decode = {ok, sl, b};
	endfunction

	// ----------------------------------------------------------------
	// Pin synchronisers and mode checks
	// ----------------------------------------------------------------
	logic [2:0] bclk_sync_q;
	logic [2:0] lrclk_sync_q;
	logic [2:0] din_sync_q;
	logic bclk_stable_q;
	logic lrclk_stable_q;
	logic din_stable_q;
	logic any_enable;
	logic mode_ok;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			bclk_sync_q <= 3'h0;
			lrclk_sync_q <= 3'h0;
			din_sync_q <= 3'h0;
			bclk_stable_q <= 1'b0;
			lrclk_stable_q <= 1'b0;
			din_stable_q <= 1'b0;
		end else begin
			bclk_sync_q <= {bclk_sync_q[1:0], bclk_in ^ cfg.bclk_invert};
			lrclk_sync_q <= {lrclk_sync_q[1:0], lrclk_in ^ cfg.lrclk_invert};
			din_sync_q <= {din_sync_q[1:0], serial_data_in};
			if (bclk_sync_q[1] == bclk_sync_q[2]) begin
				bclk_stable_q <= bclk_sync_q[2];
			end
			if (lrclk_sync_q[1] == lrclk_sync_q[2]) begin
				lrclk_stable_q <= lrclk_sync_q[2];
			end
			if (din_sync_q[1] == din_sync_q[2]) begin
				din_stable_q <= din_sync_q[2];
			end
		end
	end

	assign any_enable = |cfg.tx_enable || |cfg.rx_enable;
	// Left-justified and DSP B need both clocks mastered here
	assign mode_ok = (cfg.format == audio_serial_port_pkg::fmt_dsp_a)
		|| (cfg.format == audio_serial_port_pkg::fmt_i2s)
		|| (cfg.bclk_master && cfg.lrclk_master);
	assign cfg_error = !mode_ok;

	// ----------------------------------------------------------------
	// Master bit clock divider and bit-clock edge events
	// ----------------------------------------------------------------
	logic [audio_serial_port_pkg::DIV_W-1:0] div_cnt_q;
	logic bclk_gen_q;
	logic bclk_run;
	logic bclk_now;
	logic bclk_prev_q;
	logic rise;
	logic fall;

	assign bclk_run = cfg.bclk_master && (any_enable || cfg.bclk_force);

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			div_cnt_q <= audio_serial_port_pkg::DIV_RESET;
			bclk_gen_q <= 1'b0;
		end else if (!bclk_run) begin
			div_cnt_q <= '0;
			bclk_gen_q <= 1'b0;
		end else if (div_cnt_q >= cfg.bclk_div) begin
			div_cnt_q <= '0;
			bclk_gen_q <= ~bclk_gen_q;
		end else begin
			div_cnt_q <= div_cnt_q + 1'b1;
		end
	end

	assign bclk_now = cfg.bclk_master ? bclk_gen_q : bclk_stable_q;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			bclk_prev_q <= 1'b0;
		end else begin
			bclk_prev_q <= bclk_now;
		end
	end

	assign rise = bclk_now && !bclk_prev_q;
	assign fall = !bclk_now && bclk_prev_q;

	// ----------------------------------------------------------------
	// Frame counter; frame clock derived from the bit clock
	// ----------------------------------------------------------------
	logic [FW-1:0] bit_cnt_q;
	logic lrclk_gen_q;
	logic lrclk_prev_q;
	logic is_dsp;
	logic frame_start;
	logic [FW-1:0] half_len;
	logic [FW-1:0] bit_nxt;
	logic resync;
	logic [CW+LW:0] rx_dec;
	logic [CW+LW:0] tx_dec;
	logic [CW-1:0] cur_slot;
	logic [LW-1:0] bit_in_slot;
	logic data_bit;
	logic [CW-1:0] tx_cur_slot;
	logic [LW-1:0] tx_bit_in_slot;
	logic tx_data_bit;

	assign is_dsp = (cfg.format == audio_serial_port_pkg::fmt_dsp_a)
		|| (cfg.format == audio_serial_port_pkg::fmt_dsp_b);
	assign half_len = {1'b0, cfg.frame_len[FW-1:1]};
	// Slave frame start: frame clock edge seen at a bit-clock fall
	assign frame_start = cfg.lrclk_master
		? (fall && (bit_cnt_q == cfg.frame_len - 1'b1))
		: (fall && (lrclk_stable_q != lrclk_prev_q)
			&& (is_dsp ? lrclk_stable_q : !lrclk_stable_q));
	// Slave I2S and left-justified: the rising frame edge marks the second half
	assign resync = !cfg.lrclk_master && !is_dsp && fall && (lrclk_stable_q != lrclk_prev_q);

	// Count this fall moves to; transmit decodes it so each bit leads its receive rise
	always_comb begin
		bit_nxt = bit_cnt_q;
		if (frame_start) begin
			bit_nxt = '0;
		end else if (resync) begin
			bit_nxt = half_len;
		end else if (bit_cnt_q != {FW{1'b1}}) begin
			bit_nxt = bit_cnt_q + 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			bit_cnt_q <= '0;
			lrclk_prev_q <= 1'b0;
		end else if (fall) begin
			lrclk_prev_q <= lrclk_stable_q;
			bit_cnt_q <= bit_nxt;
		end
	end

	// Frame clock changes on the falling bit-clock edge so it is stable at the rise
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			lrclk_gen_q <= 1'b0;
		end else if (!(cfg.lrclk_master && (any_enable || cfg.lrclk_force))) begin
			lrclk_gen_q <= 1'b0;
		end else if (fall) begin
			if (is_dsp) begin
				lrclk_gen_q <= (bit_cnt_q == cfg.frame_len - 1'b1);
			end else begin
				lrclk_gen_q <= (bit_cnt_q + 1'b1 >= half_len)
					&& (bit_cnt_q != cfg.frame_len - 1'b1);
			end
		end
	end

	// Receive decodes the current count, transmit the count of the coming bit period
	assign rx_dec = slot_decode(cfg, bit_cnt_q);
	assign tx_dec = slot_decode(cfg, bit_nxt);
	assign data_bit = rx_dec[CW+LW] && mode_ok;
	assign cur_slot = rx_dec[CW+LW-1:LW];
	assign bit_in_slot = rx_dec[LW-1:0];
	assign tx_data_bit = tx_dec[CW+LW] && mode_ok;
	assign tx_cur_slot = tx_dec[CW+LW-1:LW];
	assign tx_bit_in_slot = tx_dec[LW-1:0];

	// ----------------------------------------------------------------
	// Transmit: load channel word at slot start, shift MSB first
	// ----------------------------------------------------------------
	logic [WORD_MAX-1:0] tx_shift_q;
	logic tx_active_q;
	logic dout_q;
	logic oe_q;
	logic [CHANNELS-1:0] tx_hit;
	logic [CHANNELS*WORD_MAX-1:0] tx_hold_q;
	logic [CHANNELS-1:0] tx_hold_valid_q;

	generate
		for (genvar c = 0; c < CHANNELS; c++) begin : g_tx
			assign tx_hit[c] = cfg.tx_enable[c]
				&& (slot_of(cfg.tx_slot, c) == tx_cur_slot);
			assign tx_ready[c] = !tx_hold_valid_q[c];
		end
	endgenerate

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			tx_hold_valid_q <= '0;
			tx_hold_q <= '0;
		end else begin
			for (int c = 0; c < CHANNELS; c++) begin
				if (tx_valid[c] && !tx_hold_valid_q[c]) begin
					tx_hold_valid_q[c] <= 1'b1;
					tx_hold_q[c*WORD_MAX +: WORD_MAX] <= tx_sample[c*WORD_MAX +: WORD_MAX];
				end else if (fall && tx_data_bit && tx_bit_in_slot == '0 && tx_hit[c]) begin
					tx_hold_valid_q[c] <= 1'b0;
				end
			end
		end
	end

	// Data changes on the bit-clock fall, partner samples on the rise
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			tx_shift_q <= '0;
			tx_active_q <= 1'b0;
			dout_q <= 1'b0;
			oe_q <= 1'b0;
		end else if (fall) begin
			tx_active_q <= tx_data_bit && |tx_hit;
			if (tx_data_bit && |tx_hit) begin
				if (tx_bit_in_slot == '0) begin
					for (int c = 0; c < CHANNELS; c++) begin
						if (tx_hit[c]) begin
							dout_q <= tx_hold_q[c*WORD_MAX + WORD_MAX - 1];
							tx_shift_q <= tx_hold_q[c*WORD_MAX +: WORD_MAX] << 1;
						end
					end
				end else begin
					dout_q <= tx_shift_q[WORD_MAX-1];
					tx_shift_q <= tx_shift_q << 1;
				end
				oe_q <= 1'b1;
			end else begin
				case (cfg.tdm_mode)
					audio_serial_port_pkg::tdm_tristate: oe_q <= 1'b0;
					audio_serial_port_pkg::tdm_hold_last: oe_q <= 1'b1;
					default: begin
						dout_q <= 1'b0;
						oe_q <= 1'b1;
					end
				endcase
			end
		end
	end

	assign serial_data_out = dout_q;
	assign serial_data_out_oe = oe_q && any_enable;

	// ----------------------------------------------------------------
	// Receive: sample on the rise, MSB first, deliver through buffer
	// ----------------------------------------------------------------
	logic [WORD_MAX-1:0] rx_shift_q;
	logic [CW-1:0] rx_chan_q;
	logic rx_push_q;
	logic buf_in_ready;
	logic [CHANNELS-1:0] rx_hit;
	audio_serial_port_pkg::sample_s rx_word;

	generate
		for (genvar c = 0; c < CHANNELS; c++) begin : g_rx
			assign rx_hit[c] = cfg.rx_enable[c] && (slot_of(cfg.rx_slot, c) == cur_slot);
		end
	endgenerate

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rx_shift_q <= '0;
			rx_chan_q <= '0;
			rx_push_q <= 1'b0;
			rx_overrun <= 1'b0;
		end else begin
			rx_push_q <= 1'b0;
			if (rx_push_q && !buf_in_ready) begin
				rx_overrun <= 1'b1;
			end
			if (rise && data_bit && |rx_hit) begin
				rx_shift_q <= {rx_shift_q[WORD_MAX-2:0], din_stable_q};
				for (int c = 0; c < CHANNELS; c++) begin
					if (rx_hit[c]) begin
						rx_chan_q <= CW'(c);
					end
				end
				if (bit_in_slot == cfg.word_len - 1'b1) begin
					rx_push_q <= 1'b1;
				end
			end
		end
	end

	// Left-align the received word so the sign sits at the top bit
	assign rx_word.channel = rx_chan_q;
	assign rx_word.data = rx_shift_q << (LW'(WORD_MAX) - cfg.word_len);

	sample_skid_buffer #(
		.WIDTH($bits(audio_serial_port_pkg::sample_s))
	) u_rx_buffer (
		.mclk(mclk),
		.reset_n(reset_n),
		.in_data(rx_word),
		.in_valid(rx_push_q),
		.in_ready(buf_in_ready),
		.out_data(rx_sample),
		.out_valid(rx_valid),
		.out_ready(rx_ready)
	);

	// ----------------------------------------------------------------
	// Clock pins
	// ----------------------------------------------------------------
	assign bclk_out = bclk_gen_q ^ cfg.bclk_invert;
	assign bclk_oe = cfg.bclk_master;
	assign lrclk_out = lrclk_gen_q ^ cfg.lrclk_invert;
	assign lrclk_oe = cfg.lrclk_master;
endmodule

/* src/audio_serial_port_pkg.sv */
/*
 Package for the multichannel TDM audio serial port: formats, config and sample structs,
 field widths and timing constants.
 Assumes one port instance per interface; the core clock mclk runs at 10 MHz.
*/
package audio_serial_port_pkg;
	localparam int CHANNELS = 8;
	localparam int CH_W = 3;
	localparam int WORD_MAX = 32;
	localparam int LEN_W = 6;
	localparam int FRAME_W = 10;
	localparam int DIV_W = 8;
	localparam int CLK_PERIOD_NS = 100;
	localparam int SYNC_STAGES = 3;
	localparam logic [DIV_W-1:0] DIV_RESET = 8'h02;
	localparam logic [LEN_W-1:0] SLOT_LEN_RESET = 6'h20;
	localparam logic [LEN_W-1:0] WORD_LEN_RESET = 6'h18;
	localparam logic [FRAME_W-1:0] FRAME_LEN_RESET = 10'h040;

	typedef enum logic [1:0] {
		fmt_dsp_a,
		fmt_dsp_b,
		fmt_i2s,
		fmt_left_just
	} format_e;

	typedef enum logic [1:0] {
		tdm_drive_zero,
		tdm_tristate,
		tdm_hold_last
	} tdm_mode_e;

	typedef struct packed {
		format_e format;
		logic bclk_master;
		logic lrclk_master;
		logic bclk_force;
		logic lrclk_force;
		logic bclk_invert;
		logic lrclk_invert;
		tdm_mode_e tdm_mode;
		logic [DIV_W-1:0] bclk_div;
		logic [LEN_W-1:0] slot_len;
		logic [LEN_W-1:0] word_len;
		logic [FRAME_W-1:0] frame_len;
		logic [CHANNELS-1:0] tx_enable;
		logic [CHANNELS-1:0] rx_enable;
		logic [CHANNELS*CH_W-1:0] tx_slot;
		logic [CHANNELS*CH_W-1:0] rx_slot;
	} port_cfg_s;

	typedef struct packed {
		logic [CH_W-1:0] channel;
		logic [WORD_MAX-1:0] data;
	} sample_s;
endpackage

/* src/sample_skid_buffer.sv */
/*
 Two-entry buffer with valid/ready on both sides.
 Assumes a single clock; ready on the fill side drops only when both entries are held.
*/
`timescale 1ns/1ps
module sample_skid_buffer #(
	parameter int WIDTH = 35
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	logic [WIDTH-1:0] mem_q [2];
	logic wr_ptr_q;
	logic rd_ptr_q;
	logic [1:0] count_q;
	logic push;
	logic pop;

	assign in_ready = (count_q != 2'h2);
	assign out_valid = (count_q != 2'h0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem_q[rd_ptr_q];

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			wr_ptr_q <= 1'b0;
			rd_ptr_q <= 1'b0;
			count_q <= 2'h0;
		end else begin
			if (push) begin
				wr_ptr_q <= ~wr_ptr_q;
			end
			if (pop) begin
				rd_ptr_q <= ~rd_ptr_q;
			end
			count_q <= count_q + {1'b0, push} - {1'b0, pop};
		end
	end

	always_ff @(posedge mclk) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data;
		end
	end
endmodule

/* dv/audio_serial_port_props.sv */
/*
 Checker for the audio serial port, bound to every instance of the design.
 Assumes cfg changes only away from the rising mclk edge.
*/
`timescale 1ns/1ps
module audio_serial_port_props #(
	parameter int CHANNELS = 8,
	parameter int WORD_MAX = 32
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire audio_serial_port_pkg::port_cfg_s cfg,
	input wire logic [CHANNELS*WORD_MAX-1:0] tx_sample,
	input wire logic [CHANNELS-1:0] tx_valid,
	input wire logic [CHANNELS-1:0] tx_ready,
	input wire audio_serial_port_pkg::sample_s rx_sample,
	input wire logic rx_valid,
	input wire logic rx_ready,
	input wire logic rx_overrun,
	input wire logic cfg_error,
	input wire logic serial_data_out,
	input wire logic serial_data_out_oe,
	input wire logic serial_data_in,
	input wire logic bclk_in,
	input wire logic bclk_out,
	input wire logic bclk_oe,
	input wire logic lrclk_in,
	input wire logic lrclk_out,
	input wire logic lrclk_oe
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	logic run, idle;
	logic [CHANNELS-1:0] taken;
	logic [3:0] quiet_q;
	assign run = cfg.bclk_master && (cfg.tx_enable != '0 || cfg.rx_enable != '0);
	assign idle = cfg.bclk_master && !cfg.bclk_force && !run;
	assign taken = tx_valid & tx_ready;
	// Counts cycles of an unforced master port with nothing enabled
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) quiet_q <= '0;
		else if (!idle) quiet_q <= '0;
		else if (quiet_q != 4'hf) quiet_q <= quiet_q + 4'h1;
	end
	// DSP B and left-justified hold the odd format codes
	fmt_guard_a: assert property (
		cfg_error == (cfg.format[0] && !(cfg.bclk_master && cfg.lrclk_master)))
		else $error("cfg_error does not match format and masters");
	bclk_dir_a: assert property ($stable(cfg) |-> bclk_oe == cfg.bclk_master)
		else $error("bit clock drive does not follow master setting");
	lrclk_dir_a: assert property ($stable(cfg) |-> lrclk_oe == cfg.lrclk_master)
		else $error("frame clock drive does not follow master setting");
	clk_idle_a: assert property (
		quiet_q >= 4'h8 |-> $stable(bclk_out) && $stable(lrclk_out))
		else $error("master clocks run with no channel enabled");
	clk_run_a: assert property (run && $stable(cfg) |-> ##[1:100] $changed(bclk_out))
		else $error("master bit clock stalled with channels enabled");
	frame_from_bit_a: assert property (
		run && lrclk_oe && $changed(lrclk_out) |-> $past(bclk_out) != $past(bclk_out, 2))
		else $error("frame clock moved without a bit clock edge");
	tri_quiet_a: assert property (
		(cfg.tdm_mode == audio_serial_port_pkg::tdm_tristate && cfg.tx_enable == '0)[*8]
		|-> !serial_data_out_oe)
		else $error("data pin driven with no transmit slot in tristate mode");
	rx_hold_a: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_sample))
		else $error("received sample changed before it was accepted");
	tx_take_a: assert property (|taken |=> (tx_ready & $past(taken)) == '0)
		else $error("tx_ready stayed high after a word was taken");
	cover property (rx_valid && rx_ready);
	cover property (cfg_error);
	cover property (quiet_q == 4'hf);
endmodule

bind audio_serial_port audio_serial_port_props #(.CHANNELS(CHANNELS), .WORD_MAX(WORD_MAX)) u_props (
	.mclk(mclk), .reset_n(reset_n), .cfg(cfg), .tx_sample(tx_sample), .tx_valid(tx_valid),
	.tx_ready(tx_ready), .rx_sample(rx_sample), .rx_valid(rx_valid), .rx_ready(rx_ready),
	.rx_overrun(rx_overrun), .cfg_error(cfg_error), .serial_data_out(serial_data_out),
	.serial_data_out_oe(serial_data_out_oe), .serial_data_in(serial_data_in),
	.bclk_in(bclk_in), .bclk_out(bclk_out), .bclk_oe(bclk_oe), .lrclk_in(lrclk_in),
	.lrclk_out(lrclk_out), .lrclk_oe(lrclk_oe)
);

/* dv/audio_link_partner.sv */
/*
 Link partner: makes bit and frame clocks for slave tests and loops the data wire back.
 Assumes a frame of FRAME_BITS bit clocks and no pull resistor on the data wire.
*/
`timescale 1ns/1ps
module audio_link_partner #(
	parameter int FRAME_BITS = 72
) (
	input wire logic run,
	input wire logic pulse,
	input wire logic sdo,
	input wire logic sdo_oe,
	input wire logic bclk_out,
	input wire logic bclk_oe,
	input wire logic lrclk_out,
	input wire logic lrclk_oe,
	output logic sdi,
	output logic bclk_in,
	output logic lrclk_in
);
	logic clk_q = 1'b0;
	logic fr_q = 1'b0;
	logic last_q = 1'b0;
	int bit_q = 0;
	// Bit clock runs only while slave clocks are asked for; half period above pin latency
	always #700 if (run) clk_q = ~clk_q;
	// Frame clock moves on the falling edge; a DSP pulse is one bit wide
	always @(negedge clk_q) begin
		bit_q = (bit_q + 1) % FRAME_BITS;
		fr_q = pulse ? bit_q == FRAME_BITS - 1 : bit_q >= FRAME_BITS / 2;
	end
	always @(sdo or sdo_oe) begin
		if (sdo_oe) last_q = sdo;
	end
	// A released wire shows the inverse of the last driven bit
	assign sdi = sdo_oe ? sdo : ~last_q;
	assign bclk_in = bclk_oe ? bclk_out : clk_q;
	assign lrclk_in = lrclk_oe ? lrclk_out : fr_q;
endmodule

/* dv/tb_audio_serial_port.sv */
/*
 Testbench: loopback through the link partner in every format, master and slave, with
 random slot maps, word lengths and words, then a receive stall.
 Assumes the package, design and checker sources are compiled first.
*/
`timescale 1ns/1ps
module tb_audio_serial_port;
	logic mclk, reset_n, rx_valid, rx_ready, rx_overrun, cfg_error, sdo, sdo_oe, sdi;
	logic bclk_in, bclk_out, bclk_oe, lrclk_in, lrclk_out, lrclk_oe;
	logic run, pulse, chk, stall;
	audio_serial_port_pkg::port_cfg_s cfg;
	audio_serial_port_pkg::sample_s rx_sample;
	logic [255:0] tx_sample;
	logic [7:0] tx_valid, tx_ready;
	logic [31:0] exp_w [8];
	int err_total = 0;
	int num_checks = 0;
	int seed = 32'h949b1e34;
	int cycles = 0;
	int got = 0;

	audio_serial_port uut (
		.mclk(mclk), .reset_n(reset_n), .cfg(cfg), .tx_sample(tx_sample),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .rx_sample(rx_sample), .rx_valid(rx_valid),
		.rx_ready(rx_ready), .rx_overrun(rx_overrun), .cfg_error(cfg_error),
		.serial_data_out(sdo), .serial_data_out_oe(sdo_oe), .serial_data_in(sdi),
		.bclk_in(bclk_in), .bclk_out(bclk_out), .bclk_oe(bclk_oe),
		.lrclk_in(lrclk_in), .lrclk_out(lrclk_out), .lrclk_oe(lrclk_oe)
	);
	audio_link_partner #(.FRAME_BITS(72)) peer (
		.run(run), .pulse(pulse), .sdo(sdo), .sdo_oe(sdo_oe), .bclk_out(bclk_out),
		.bclk_oe(bclk_oe), .lrclk_out(lrclk_out), .lrclk_oe(lrclk_oe), .sdi(sdi),
		.bclk_in(bclk_in), .lrclk_in(lrclk_in)
	);

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	// Nine tests of about 4600 cycles each
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 60000) begin
			err_total++;
			wrap_up();
		end
	end

	function automatic logic [31:0] trim(input logic [31:0] w, input logic [5:0] n);
		return w & ~(32'hffffffff >> n);
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	// Receiver stalls at random; every word accepted while chk is set is compared
	always @(negedge mclk) begin
		rx_ready = !stall && ($random(seed) & 1);
		if (chk && rx_valid && rx_ready) begin
			got++;
			check(32'(cfg.rx_enable[rx_sample.channel]), 32'h1);
			check(rx_sample.data, exp_w[rx_sample.channel]);
		end
	end

	task automatic run_test(input int i, input logic hold);
		int c;
		logic [2:0] k1, k2;
		logic [7:0] te, re;
		logic bad;
		@(negedge mclk);
		k1 = 3'($random(seed));
		k2 = 3'($random(seed));
		te = 8'($random(seed)) | 8'h01;
		reset_n = 1'b0;
		stall = hold;
		cfg = '0;
		cfg.format = audio_serial_port_pkg::format_e'(i % 4);
		cfg.bclk_master = i < 4;
		cfg.lrclk_master = i < 4;
		cfg.bclk_invert = i == 1 || i == 3;
		cfg.lrclk_invert = i == 1 || i == 3;
		cfg.bclk_force = i == 2;
		cfg.lrclk_force = i == 2;
		cfg.tdm_mode = audio_serial_port_pkg::tdm_mode_e'(i % 3);
		// Receive needs a bit-clock half period longer than the data pin sync latency
		cfg.bclk_div = 8'h05 + 8'($random(seed) & 1);
		cfg.slot_len = 6'h08;
		cfg.word_len = 6'(4 + $unsigned($random(seed)) % 5);
		cfg.frame_len = 10'h048;
		// Distinct rotations keep every slot on one channel only
		for (int n = 0; n < 8; n++) begin
			cfg.tx_slot[n*3 +: 3] = 3'(n) + k1;
			cfg.rx_slot[n*3 +: 3] = 3'(n) + k2;
			tx_sample[n*32 +: 32] = $random(seed);
		end
		for (int n = 0; n < 8; n++) begin
			c = (n + k2 - k1) & 7;
			exp_w[n] = trim(tx_sample[c*32 +: 32], cfg.word_len);
			re[n] = te[c];
		end
		bad = i >= 4 && i % 2 == 1;
		pulse = i % 4 < 2;
		run = i >= 4;
		tx_valid = 8'hff;
		repeat (20) @(negedge mclk);
		reset_n = 1'b1;
		repeat (100) @(negedge mclk);
		cfg.tx_enable = te;
		cfg.rx_enable = re;
		repeat (2200) @(negedge mclk);
		got = 0;
		chk = 1'b1;
		repeat (2300) @(negedge mclk);
		chk = 1'b0;
		check(32'(cfg_error), 32'(bad));
		check(32'(got > 0), 32'(!bad && !hold));
		check(32'(rx_overrun), 32'(hold));
		$display("test %0d done, %0d words", i, got);
	endtask

	initial begin
		reset_n = 1'b0;
		cfg = '0;
		tx_sample = '0;
		tx_valid = '0;
		rx_ready = 1'b0;
		run = 1'b0;
		pulse = 1'b0;
		chk = 1'b0;
		stall = 1'b0;
		for (int i = 0; i < 9; i++) run_test(i % 8, i == 8);
		wrap_up();
	end
endmodule
